//--- src/itb_elem.sv
// Purpose: counting element and output control of one timer channel
// Assumes: counter clock and gate pins synchronous to clk_sys_in
// Notes: counts on the falling edge of the counter clock pin
`include "itb_map.svh"
module itb_elem
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic cnt_clk_in,
   input wire logic gate_in,
   input wire logic prog_in,
   input wire logic [2:0] mode_in,
   input wire logic bcd_in,
   input wire logic load_in,
   input wire logic [15:0] load_val_in,
   output logic [15:0] count_out,
   output logic out_out,
   output logic null_out
);

   itb_pkg::itb_elem_st_t q, n;
   logic tick;
   logic trig_m;
   logic rate;
   logic sq;
   logic strobe;
   logic [15:0] nc;

   function automatic logic [15:0] itb_dec(input logic [15:0] v,
                                           input logic bcd);
      logic [15:0] r;
      logic borrow;
      r = v - 16'h0001;
      borrow = 1'b1;
      if (bcd)
      begin
         r = v;
         for (int i = 0; i < 4; i++)
         begin
            if (borrow)
            begin
               if (v[i*4 +: 4] == 4'h0)
                  r[i*4 +: 4] = 4'h9;
               else
               begin
                  r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction : itb_dec

   assign tick = q.clk_q & ~cnt_clk_in;
   assign trig_m = (mode_in[1:0] == 2'h1);
   assign rate = mode_in[1];
   assign sq = (mode_in[1:0] == 2'h3);
   assign strobe = mode_in[2] & ~mode_in[1];

   always_comb
   begin
      n = q;
      nc = itb_dec(q.cnt, bcd_in);
      n.clk_q = cnt_clk_in;
      n.gate_q = gate_in;
      if (gate_in && !q.gate_q && trig_m)
         n.trig = 1'b1;
      if (!gate_in && rate)
         n.out = 1'b1;
      if (prog_in)
      begin
         n.out = (mode_in != 3'h0);
         n.null_f = 1'b1;
         n.pend = 1'b0;
         n.trig = 1'b0;
         n.phase = itb_pkg::ITB_PH_IDLE;
      end
      else if (load_in)
      begin
         n.pend = 1'b1;
         n.null_f = 1'b1;
         if (mode_in == 3'h0)
            n.out = 1'b0;
      end
      else if (tick)
      begin
         if ((q.pend && !trig_m) || q.trig)
         begin
            n.cnt = load_val_in;
            n.pend = 1'b0;
            n.null_f = 1'b0;
            n.trig = 1'b0;
            n.phase = itb_pkg::ITB_PH_RUN;
            if (trig_m && !mode_in[2])
               n.out = 1'b0;
         end
         else if (q.phase == itb_pkg::ITB_PH_RUN && (gate_in || trig_m))
         begin
            if (sq)
            begin
               if (q.cnt <= 16'h0002)
               begin
                  n.cnt = load_val_in;
                  n.out = ~q.out;
               end
               else
                  n.cnt = itb_dec(nc, bcd_in);
            end
            else if (rate)
            begin
               n.cnt = (q.cnt == 16'h0001) ? load_val_in : nc;
               n.out = (q.cnt != 16'h0002);
            end
            else
            begin
               n.cnt = nc;
               if (nc == 16'h0000)
               begin
                  n.out = ~strobe;
                  n.phase = itb_pkg::ITB_PH_DONE;
               end
            end
         end
         else if (q.phase == itb_pkg::ITB_PH_DONE && strobe)
            n.out = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         q <= '0;
      else
         q <= n;
   end

   assign count_out = q.cnt;
   assign out_out = q.out;
   assign null_out = q.null_f;

   chk_load_whole: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (tick && q.pend && !trig_m && !prog_in && !load_in)
      |=> (q.cnt == $past(load_val_in)) && !q.null_f)
      else $error("count not loaded as one word");

   chk_terminal_out: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (tick && mode_in == 3'h0 && gate_in && q.phase == itb_pkg::ITB_PH_RUN
       && q.cnt == 16'h0001 && !q.pend && !prog_in && !load_in)
      |=> out_out ##1 (out_out || $past(prog_in) || $past(load_in)))
      else $error("output did not rise at terminal count");

endmodule : itb_elem

//--- src/itb_map.svh
// Purpose: offsets, field positions and reset values of the interval timer
// Assumes: 8-bit host data bus, four ports selected by a 2-bit code
// Notes: definitions only
`ifndef ITB_MAP_SVH
`define ITB_MAP_SVH

// ----------------------------------------------------------------------
// port codes
// ----------------------------------------------------------------------
`define ITB_PORT_CNT0 2'h0
`define ITB_PORT_CNT1 2'h1
`define ITB_PORT_CNT2 2'h2
`define ITB_PORT_CFG 2'h3
`define ITB_NUM_CNT 3

// ----------------------------------------------------------------------
// configuration word fields
// ----------------------------------------------------------------------
`define ITB_F_SEL 7:6
`define ITB_F_ACC 5:4
`define ITB_F_MODE 3:1
`define ITB_F_BCD 0
`define ITB_F_KEEP 5:0
`define ITB_SEL_RDBK 2'h3
`define ITB_ACC_LATCH 2'h0
`define ITB_ACC_LO 2'h1
`define ITB_ACC_HI 2'h2
`define ITB_ACC_BOTH 2'h3
// read-back: low-active count and status latch bits
`define ITB_RB_NCNT 5
`define ITB_RB_NSTAT 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ITB_RST_BYTE 8'h00
`define ITB_RST_CW 6'h00
`define ITB_RST_CNT 16'h0000

`endif

//--- src/itb_pkg.sv
// Purpose: types of the interval timer
// Assumes: itb_map.svh supplies the counter count
// Notes: state of each module is one packed struct
`include "itb_map.svh"
package itb_pkg;

   typedef enum logic [2:0] {
      ITB_PH_IDLE = 3'b001,
      ITB_PH_RUN = 3'b010,
      ITB_PH_DONE = 3'b100
   } itb_phase_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic out;
      logic pend;
      logic null_f;
      logic trig;
      logic clk_q;
      logic gate_q;
      itb_phase_t phase;
   } itb_elem_st_t;

   typedef struct packed {
      logic [`ITB_NUM_CNT-1:0][5:0] cw;
      logic [`ITB_NUM_CNT-1:0][7:0] holding_high;
      logic [`ITB_NUM_CNT-1:0][7:0] holding_low;
      logic [`ITB_NUM_CNT-1:0][15:0] count_snapshot;
      logic [`ITB_NUM_CNT-1:0] frozen;
      logic [`ITB_NUM_CNT-1:0][7:0] status;
      logic [`ITB_NUM_CNT-1:0] stat_vld;
      logic [`ITB_NUM_CNT-1:0] wr_ptr;
      logic [`ITB_NUM_CNT-1:0] rd_ptr;
      logic [`ITB_NUM_CNT-1:0] load;
      logic [`ITB_NUM_CNT-1:0] prog;
      logic wr_sel;
      logic rd_sel;
      logic [1:0] rd_port;
      logic [7:0] dout;
   } itb_top_st_t;

endpackage : itb_pkg

//--- src/itb_top.sv
// Purpose: host bus interface and three counter channels of the timer
// Assumes: strobes, select and data synchronous to clk_sys_in
// Notes: one counting element per channel in itb_elem
//
// Behaviour
// - port code 00,01,10 picks counters 0..2; 11 the configuration port
// - read and write strobes act only while device select is low
// - 8-bit data bus driven only during a selected read
// - write to port 11 stores and decodes a configuration word
// - configuration port is write-only; its read returns no contents
// - three identical independent channels, each with its own mode
// - counting element is a 16-bit presettable down counter
// - byte-wide snapshot pair tracks the count when not frozen
// - latch command freezes snapshot until read, then tracking resumes
// - counter reads return snapshot or latched status bytes, one byte per access
// - written count goes to holding register, later to counter
// - holding register loads one byte per write access
// - both holding bytes move into the counter together
// - programming clears holding register so unwritten byte is zero
// - status latch captures configuration, output and pending-load flag
// - clock, gate and output pins pass only through channel control
// - output signals the host when the programmed delay expires
// - word layout: select 7:6, access 5:4, mode 3:1, decimal 0
// - select 11 is read-back; access 01 low, 10 high, 11 both
// - access field 00 is a latch command for the selected counter
`include "itb_map.svh"
module itb_top
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [1:0] port_select_in,
   input wire logic dev_sel_n_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_out,
   input wire logic [2:0] cnt_clk_in,
   input wire logic [2:0] gate_in,
   output logic [2:0] timer_out
);

   // ----------------------------------------------------------------------
   // state and channel wiring
   // ----------------------------------------------------------------------
   itb_pkg::itb_top_st_t q, n;
   logic [`ITB_NUM_CNT-1:0][15:0] elem_cnt;
   logic [`ITB_NUM_CNT-1:0] elem_out;
   logic [`ITB_NUM_CNT-1:0] elem_null;
   logic wr_go;
   logic rd_now;
   logic rd_end;
   logic [1:0] wsel;
   logic [1:0] wacc;

   genvar g;
   generate
      for (g = 0; g < `ITB_NUM_CNT; g++)
      begin : gen_chan
         itb_elem u_elem
         (
            .clk_sys_in(clk_sys_in),
            .sys_rst_in(sys_rst_in),
            .cnt_clk_in(cnt_clk_in[g]),
            .gate_in(gate_in[g]),
            .prog_in(q.prog[g]),
            .mode_in(q.cw[g][`ITB_F_MODE]),
            .bcd_in(q.cw[g][`ITB_F_BCD]),
            .load_in(q.load[g]),
            .load_val_in({q.holding_high[g], q.holding_low[g]}),
            .count_out(elem_cnt[g]),
            .out_out(elem_out[g]),
            .null_out(elem_null[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // strobe qualification
   // ----------------------------------------------------------------------
   assign wr_go = ~dev_sel_n_in & ~wr_n_in & ~q.wr_sel;
   assign rd_now = ~dev_sel_n_in & ~rd_n_in;
   assign rd_end = q.rd_sel & ~rd_now;
   assign wsel = data_in[`ITB_F_SEL];
   assign wacc = data_in[`ITB_F_ACC];

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      n = q;
      n.load = '0;
      n.prog = '0;
      n.wr_sel = ~dev_sel_n_in & ~wr_n_in;
      n.rd_sel = rd_now;
      if (rd_now)
         n.rd_port = port_select_in;
      for (int i = 0; i < `ITB_NUM_CNT; i++)
      begin
         if (!q.frozen[i])
            n.count_snapshot[i] = elem_cnt[i];
      end

      // end of a counter read moves the byte pointer on
      if (rd_end && q.rd_port != `ITB_PORT_CFG)
      begin
         if (q.stat_vld[q.rd_port])
            n.stat_vld[q.rd_port] = 1'b0;
         else if (q.cw[q.rd_port][`ITB_F_ACC] == `ITB_ACC_BOTH
                  && !q.rd_ptr[q.rd_port])
            n.rd_ptr[q.rd_port] = 1'b1;
         else
         begin
            n.rd_ptr[q.rd_port] = 1'b0;
            n.frozen[q.rd_port] = 1'b0;
         end
      end

      if (wr_go)
      begin
         if (port_select_in == `ITB_PORT_CFG)
         begin
            if (wsel == `ITB_SEL_RDBK)
            begin
               for (int i = 0; i < `ITB_NUM_CNT; i++)
               begin
                  if (data_in[i+1])
                  begin
                     if (!data_in[`ITB_RB_NCNT])
                        n.frozen[i] = 1'b1;
                     if (!data_in[`ITB_RB_NSTAT] && !n.stat_vld[i])
                     begin
                        n.stat_vld[i] = 1'b1;
                        n.status[i] = {elem_out[i], elem_null[i], q.cw[i]};
                     end
                  end
               end
            end
            else if (wacc == `ITB_ACC_LATCH)
               n.frozen[wsel] = 1'b1;
            else
            begin
               n.cw[wsel] = data_in[`ITB_F_KEEP];
               n.holding_high[wsel] = `ITB_RST_BYTE;
               n.holding_low[wsel] = `ITB_RST_BYTE;
               n.wr_ptr[wsel] = 1'b0;
               n.rd_ptr[wsel] = 1'b0;
               n.frozen[wsel] = 1'b0;
               n.stat_vld[wsel] = 1'b0;
               n.prog[wsel] = 1'b1;
            end
         end
         else
         begin
            // count bytes land in the holding register only
            unique case (q.cw[port_select_in][`ITB_F_ACC])
               `ITB_ACC_LO:
               begin
                  n.holding_low[port_select_in] = data_in;
                  n.load[port_select_in] = 1'b1;
               end
               `ITB_ACC_HI:
               begin
                  n.holding_high[port_select_in] = data_in;
                  n.load[port_select_in] = 1'b1;
               end
               `ITB_ACC_BOTH:
               begin
                  if (!q.wr_ptr[port_select_in])
                  begin
                     n.holding_low[port_select_in] = data_in;
                     n.wr_ptr[port_select_in] = 1'b1;
                  end
                  else
                  begin
                     n.holding_high[port_select_in] = data_in;
                     n.wr_ptr[port_select_in] = 1'b0;
                     n.load[port_select_in] = 1'b1;
                  end
               end
               `ITB_ACC_LATCH:
               begin
                  // unprogrammed channel: byte is dropped
               end
            endcase
         end
      end

      // read data: snapshot or status, never the live count
      n.dout = `ITB_RST_BYTE;
      if (port_select_in != `ITB_PORT_CFG)
      begin
         if (q.stat_vld[port_select_in])
            n.dout = q.status[port_select_in];
         else
         begin
            unique case (q.cw[port_select_in][`ITB_F_ACC])
               `ITB_ACC_LO:
                  n.dout = q.count_snapshot[port_select_in][7:0];
               `ITB_ACC_HI:
                  n.dout = q.count_snapshot[port_select_in][15:8];
               `ITB_ACC_BOTH:
                  n.dout = q.rd_ptr[port_select_in]
                         ? q.count_snapshot[port_select_in][15:8]
                         : q.count_snapshot[port_select_in][7:0];
               `ITB_ACC_LATCH:
                  n.dout = `ITB_RST_BYTE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         q <= '0;
      else
         q <= n;
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign data_out = q.dout;
   assign data_oe_out = rd_now;
   assign timer_out = elem_out;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   chk_deselect_ignored: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      dev_sel_n_in |=> $stable(q.cw) && $stable(q.holding_low)
                       && $stable(q.holding_high) && $stable(q.wr_ptr))
      else $error("strobe acted while deselected");

   chk_bus_drive: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (dev_sel_n_in || rd_n_in) |-> !data_oe_out)
      else $error("data bus driven outside a selected read");

   chk_cw_store: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (wr_go && port_select_in == `ITB_PORT_CFG && wsel == 2'h0
       && wacc != `ITB_ACC_LATCH)
      |=> q.cw[0] == $past(data_in[`ITB_F_KEEP]) && q.prog[0]
          ##1 !q.prog[0])
      else $error("configuration word not stored for channel 0");

   chk_cw_read_zero: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (rd_now && port_select_in == `ITB_PORT_CFG)
      |=> data_out == `ITB_RST_BYTE)
      else $error("configuration port returned contents");

   chk_snap_track: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      !q.frozen[0] |=> q.count_snapshot[0] == $past(elem_cnt[0]))
      else $error("snapshot not tracking the count");

   chk_latch_freeze: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (q.frozen[0] && !(wr_go && port_select_in == `ITB_PORT_CFG))
      |=> $stable(q.count_snapshot[0]))
      else $error("frozen snapshot changed");

   chk_latch_cmd: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (wr_go && port_select_in == `ITB_PORT_CFG && data_in[7:4] == 4'h0)
      |=> q.frozen[0] && $stable(q.cw[0]))
      else $error("latch command not applied to channel 0");

   chk_hold_one_byte: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (wr_go && port_select_in == `ITB_PORT_CNT0)
      |=> $stable(q.holding_high[0]) || $stable(q.holding_low[0]))
      else $error("two holding bytes loaded by one write");

   chk_single_clear: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (wr_go && port_select_in == `ITB_PORT_CFG && wsel == 2'h0
       && wacc == `ITB_ACC_LO)
      |=> q.holding_high[0] == `ITB_RST_BYTE
          && q.holding_low[0] == `ITB_RST_BYTE)
      else $error("holding register not cleared on programming");

   chk_status_latch: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (wr_go && port_select_in == `ITB_PORT_CFG && wsel == `ITB_SEL_RDBK
       && data_in[1] && !data_in[`ITB_RB_NSTAT] && !q.stat_vld[0])
      |=> q.stat_vld[0] && q.status[0][5:0] == q.cw[0]
          && q.status[0][7] == $past(elem_out[0]))
      else $error("status not latched for channel 0");

endmodule : itb_top

//--- tb/itb_host.sv
// Purpose: host processor model driving the timer's parallel port
// Assumes: one access at a time, strobes changed just after clk edges
// Notes: released data lines show the inverse of the last byte
module itb_host
(
   input wire logic clk_sys_in,
   input wire logic [7:0] bus_in,
   input wire logic bus_oe_in,
   output logic [1:0] port_select_out,
   output logic dev_sel_n_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic [7:0] drive_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------
   initial
   begin
      port_select_out = 2'h0;
      dev_sel_n_out = 1'b1;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      drive_out = 8'h00;
   end

   task automatic wr(input logic sel_n, input logic [1:0] port,
                     input logic [7:0] val);
      @(posedge clk_sys_in);
      dev_sel_n_out <= sel_n;
      port_select_out <= port;
      drive_out <= val;
      wr_n_out <= 1'b0;
      @(posedge clk_sys_in);
      wr_n_out <= 1'b1;
      dev_sel_n_out <= 1'b1;
      drive_out <= ~val;
      @(posedge clk_sys_in);
   endtask : wr

   task automatic rd(input logic sel_n, input logic [1:0] port,
                     output logic [7:0] val, output logic oe);
      @(posedge clk_sys_in);
      dev_sel_n_out <= sel_n;
      port_select_out <= port;
      rd_n_out <= 1'b0;
      @(posedge clk_sys_in);
      // registered read byte is taken mid-cycle, where it has settled
      @(negedge clk_sys_in);
      val = bus_in;
      oe = bus_oe_in;
      @(posedge clk_sys_in);
      rd_n_out <= 1'b1;
      dev_sel_n_out <= 1'b1;
      @(posedge clk_sys_in);
   endtask : rd
endmodule : itb_host

//--- tb/testbench.sv
// Purpose: self-checking bench of the interval timer top
// Assumes: counter clocks slow against clk_sys_in, gates high unless tested
// Notes: ordinary programming cases come from a table of rows
`include "itb_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [7:0] cw;
      logic [7:0] lo;
      logic [7:0] hi;
      logic [15:0] exp;
   } itb_row_t;

   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [2:0] cnt_clk = 3'h7;
   logic [2:0] gate = 3'h7;
   logic [1:0] port_select;
   logic dev_sel_n, rd_n, wr_n, data_oe;
   logic [7:0] host_drv, dut_dout, bus, v;
   logic [2:0] timer_out;
   logic [1:0] ch, acc;
   logic oe;
   int num_errors = 0;
   int comparisons = 0;
   itb_row_t rows [4] = '{'{8'h30, 8'h34, 8'h12, 16'h1234},
                          '{8'h58, 8'hA5, 8'h00, 16'h00A5},
                          '{8'hA0, 8'h00, 8'h5A, 16'h5A00},
                          '{8'hB9, 8'h99, 8'h09, 16'h0999}};

   always #25 clk_sys_in = ~clk_sys_in;
   assign bus = data_oe ? dut_dout : host_drv;

   itb_top dut
   (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .port_select_in(port_select),
      .dev_sel_n_in(dev_sel_n),
      .rd_n_in(rd_n),
      .wr_n_in(wr_n),
      .data_in(bus),
      .data_out(dut_dout),
      .data_oe_out(data_oe),
      .cnt_clk_in(cnt_clk),
      .gate_in(gate),
      .timer_out(timer_out)
   );

   itb_host host
   (
      .clk_sys_in(clk_sys_in),
      .bus_in(bus),
      .bus_oe_in(data_oe),
      .port_select_out(port_select),
      .dev_sel_n_out(dev_sel_n),
      .rd_n_out(rd_n),
      .wr_n_out(wr_n),
      .drive_out(host_drv)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic rdc(input logic [1:0] port, input logic [7:0] exp);
      host.rd(1'b0, port, v, oe);
      check({7'h00, oe, v}, {8'h01, exp});
   endtask : rdc

   // one falling then rising edge per tick, two clk cycles per level
   task automatic tick(input logic [1:0] c, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_sys_in);
         cnt_clk[c] <= 1'b0;
         repeat (2) @(posedge clk_sys_in);
         cnt_clk[c] <= 1'b1;
         repeat (2) @(posedge clk_sys_in);
      end
   endtask : tick

   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      num_errors++;
      $display("BAD t=%0t run did not finish", $time);
      end_of_test;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      check({13'h0000, timer_out}, 16'h0000);
      rdc(`ITB_PORT_CNT0, 8'h00);
      $display("reset test done");
      foreach (rows[i])
      begin
         ch = rows[i].cw[`ITB_F_SEL];
         acc = rows[i].cw[`ITB_F_ACC];
         host.wr(1'b0, `ITB_PORT_CFG, rows[i].cw);
         if (acc[0])
            host.wr(1'b0, ch, rows[i].lo);
         if (acc[1])
            host.wr(1'b0, ch, rows[i].hi);
         tick(ch, 1);
         host.wr(1'b0, `ITB_PORT_CFG, {ch, 6'h00});
         if (acc[0])
            rdc(ch, rows[i].exp[7:0]);
         if (acc[1])
            rdc(ch, rows[i].exp[15:8]);
         $display("row %0d done", i);
      end
      // channel 0 untouched by later programming of the others
      host.wr(1'b0, `ITB_PORT_CFG, 8'h00);
      rdc(`ITB_PORT_CNT0, 8'h34);
      rdc(`ITB_PORT_CNT0, 8'h12);
      $display("independence test done");
      host.wr(1'b0, `ITB_PORT_CFG, 8'h70);
      host.wr(1'b0, `ITB_PORT_CNT1, 8'h02);
      tick(2'h1, 1);
      host.wr(1'b0, `ITB_PORT_CNT1, 8'h01);
      tick(2'h1, 1);
      host.wr(1'b0, `ITB_PORT_CFG, 8'h40);
      tick(2'h1, 1);
      rdc(`ITB_PORT_CNT1, 8'h02);
      rdc(`ITB_PORT_CNT1, 8'h01);
      rdc(`ITB_PORT_CNT1, 8'h01);
      rdc(`ITB_PORT_CNT1, 8'h01);
      $display("latch test done");
      host.wr(1'b1, `ITB_PORT_CFG, 8'h90);
      host.wr(1'b1, `ITB_PORT_CNT2, 8'h11);
      host.rd(1'b1, `ITB_PORT_CNT2, v, oe);
      check({15'h0000, oe}, 16'h0000);
      host.wr(1'b0, `ITB_PORT_CFG, 8'h80);
      rdc(`ITB_PORT_CNT2, 8'h99);
      rdc(`ITB_PORT_CNT2, 8'h09);
      rdc(`ITB_PORT_CFG, 8'h00);
      $display("select test done");
      host.wr(1'b0, `ITB_PORT_CFG, 8'h10);
      host.wr(1'b0, `ITB_PORT_CNT0, 8'h03);
      tick(2'h0, 3);
      check({15'h0000, timer_out[0]}, 16'h0000);
      tick(2'h0, 1);
      check({15'h0000, timer_out[0]}, 16'h0001);
      host.wr(1'b0, `ITB_PORT_CFG, 8'hE2);
      rdc(`ITB_PORT_CNT0, 8'h90);
      $display("expiry and status test done");
      // rate mode: one-tick low output at count 1, gate low stops it
      host.wr(1'b0, `ITB_PORT_CFG, 8'h54);
      host.wr(1'b0, `ITB_PORT_CNT1, 8'h03);
      tick(2'h1, 2);
      check({15'h0000, timer_out[1]}, 16'h0001);
      tick(2'h1, 1);
      check({15'h0000, timer_out[1]}, 16'h0000);
      gate[1] <= 1'b0;
      tick(2'h1, 1);
      check({15'h0000, timer_out[1]}, 16'h0001);
      rdc(`ITB_PORT_CNT1, 8'h01);
      gate[1] <= 1'b1;
      $display("rate mode test done");
      @(posedge clk_sys_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      check({13'h0000, timer_out}, 16'h0000);
      rdc(`ITB_PORT_CNT1, 8'h00);
      $display("second reset test done");
      end_of_test;
   end
endmodule : testbench
